// ### rtl/ioa_cycle_allocator.sv
// Memory cycle allocator between transfer channels and the processor
// Summary of operation
// R1 - Memory cycles are offered to channels in rotation, one channel each.
// R2 - Offered channel with demand is granted memory for that one cycle.
// R3 - Unclaimed cycle goes to the processor.
// R4 - Banked mode: same block conflict, I/O wins, processor waits one cycle.
// R5 - Banked mode: different blocks proceed together, no processor stall.
// R6 - Every I/O grant moves one character, never a word.
// R7 - Slot of an absent optional channel goes to the processor.
// R8 - Missing first auxiliary: its slot is offered to the first primary.
// R9 - Optionally every fourth memory cycle is reserved for the processor.
// R10 - A channel without auxiliary partner is offered every round.
// R11 - Primary slot alternates between primary and auxiliary each round.
// R12 - Paired channels each get an offer every second round.
// R13 - Interlocked channels give all their slots to the owning transfer.
// R14 - When interlock ends, normal rotation resumes.
// R15 - Variable speed: one to six offers per window, set by rate code.
// R16 - Variable speed assignment busies only a primary and its auxiliary.
// R17 - Sum of rates within one sector is capped at six units.
// R18 - Sector escape moves a channel into the other sector.
// R19 - The requester names a channel of the device's sector or escapes.
// R20 - Each memory cycle has exactly one owner.
`timescale 1ns/10ps
`default_nettype none
`include "ioa_defs.svh"
module ioa_cycle_allocator #(
    parameter int                  NPRI        = `IOA_NPRI,
    parameter logic [NPRI-1:0]     AUX_MAP     = `IOA_SLOT_MAP,
    parameter logic [NPRI-1:0]     HOME_SECTOR = `IOA_HOME_SECTOR,
    parameter int                  MEM_CYC_NS  = `IOA_MEM_CYCLE_NS
) (
    input  wire logic                          clk_in,
    input  wire logic                          resetn_in,
    input  wire ioa_pkg::ioa_cfg_t             cfg_in,
    input  wire logic [2*NPRI-1:0]             installed_in,
    input  wire logic [2*NPRI-1:0]             demand_in,
    input  wire ioa_pkg::ioa_ilk_t             ilk_in,
    input  wire logic [NPRI*`IOA_RATE_W-1:0]   rate_code_in,
    input  wire logic [NPRI-1:0]               escape_in,
    input  wire logic [2*NPRI*`IOA_BLK_W-1:0]  io_block_in,
    input  wire logic                          proc_req_in,
    input  wire logic [`IOA_BLK_W-1:0]         proc_block_in,
    output ioa_pkg::ioa_grant_t                offer_out,
    output ioa_pkg::ioa_grant_t                grant_out,
    output logic [2*NPRI:0]                    owner_out,
    output logic                               proc_go_out,
    output logic                               proc_stall_out,
    output logic [NPRI-1:0]                    pair_busy_out
);
    localparam int NCH = 2 * NPRI;
    // Memory cycle length in clocks, rounded up; at least two for the table read
    localparam int MEM_CLKS_RAW = (MEM_CYC_NS + `IOA_CLK_NS - 1) / `IOA_CLK_NS;
    localparam int MEM_CLKS = (MEM_CLKS_RAW < 2) ? 2 : MEM_CLKS_RAW;
    localparam logic [`IOA_CNT_W-1:0] MEM_LAST = `IOA_CNT_W'(MEM_CLKS - 1);
    localparam logic [`IOA_CIW-2:0] SLOT_LAST = (`IOA_CIW-1)'(NPRI - 1);

    // Rate code clamped into the legal one to six range
    function automatic logic [2:0] clamp_rate(input logic [2:0] code);
        if (code < `IOA_RATE_MIN) begin
            clamp_rate = `IOA_RATE_MIN;
        end else if (code > `IOA_RATE_MAX) begin
            clamp_rate = `IOA_RATE_MAX;
        end else begin
            clamp_rate = code;
        end
    endfunction : clamp_rate

    // Grants rate to each primary in index order until its sector is full
    function automatic logic [NPRI*3-1:0] sector_rates(
        input logic [NPRI*3-1:0] codes,
        input logic [NPRI-1:0]   sector
    );
        logic [3:0] used0;
        logic [3:0] used1;
        logic [3:0] room;
        logic [2:0] want;
        logic [2:0] give;
        used0 = 4'h0;
        used1 = 4'h0;
        sector_rates = '0;
        for (int i = 0; i < NPRI; i++) begin
            want = clamp_rate(codes[i*3 +: 3]);
            room = `IOA_SECTOR_CAP - (sector[i] ? used1 : used0);
            give = ({1'b0, want} > room) ? room[2:0] : want;
            sector_rates[i*3 +: 3] = give;
            if (sector[i]) begin
                used1 = used1 + {1'b0, give};
            end else begin
                used0 = used0 + {1'b0, give};
            end
        end
    endfunction : sector_rates

    // Count up and wrap to zero after the last value
    function automatic logic [2:0] wrap_inc(
        input logic [2:0] value,
        input logic [2:0] last
    );
        wrap_inc = (value == last) ? 3'd0 : value + 3'd1;
    endfunction : wrap_inc

    // Memory block addressed by one channel
    function automatic logic [`IOA_BLK_W-1:0] block_of(
        input logic [2*NPRI*`IOA_BLK_W-1:0] blocks,
        input logic [`IOA_CIW-1:0]          chan
    );
        block_of = blocks[chan*`IOA_BLK_W +: `IOA_BLK_W];
    endfunction : block_of

    ioa_pkg::ioa_slot_t slot_data;

    // Registered state, each with its next value
    logic [`IOA_CNT_W-1:0]   div_reg;
    logic [`IOA_CNT_W-1:0]   div_next;
    logic [`IOA_CIW-2:0]     slot_reg;
    logic [`IOA_CIW-2:0]     slot_next;
    logic                    round_reg;
    logic                    round_next;
    logic [1:0]              res_reg;
    logic [1:0]              res_next;
    logic [2:0]              vs_reg;
    logic [2:0]              vs_next;
    ioa_pkg::ioa_grant_t     offer_reg;
    ioa_pkg::ioa_grant_t     offer_next;
    ioa_pkg::ioa_grant_t     grant_reg;
    ioa_pkg::ioa_grant_t     grant_next;
    logic [2*NPRI:0]         owner_reg;
    logic [2*NPRI:0]         owner_next;
    logic                    go_reg;
    logic                    go_next;
    logic                    stall_reg;
    logic                    stall_next;
    logic [NPRI-1:0]         busy_reg;
    logic [NPRI-1:0]         busy_next;

    // Slot decode, only meaningful at a tick
    logic                    tick;
    logic                    reserved;
    logic                    to_proc;
    logic [`IOA_CIW-1:0]     target;
    logic [`IOA_CIW-1:0]     aux_idx;
    logic [NPRI*3-1:0]       eff_rate;
    logic [`IOA_BLK_W-1:0]   chan_block;

    // Table read lags the slot by one clock, hence at least two clocks per cycle
    ioa_slot_rom #(
        .NPRI    (NPRI),
        .AUX_MAP (AUX_MAP)
    ) u_slot_rom (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .addr_in   (slot_reg),
        .data_out  (slot_data)
    );

    // Divider: one tick per memory cycle; slot, round, offer, grant, owner and processor state step on it
    always_comb begin
        tick     = (div_reg == MEM_LAST);
        div_next = tick ? '0 : div_reg + `IOA_CNT_W'(1);
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    // Decode of the slot that the coming tick hands out
    always_comb begin
        eff_rate   = sector_rates(rate_code_in, HOME_SECTOR ^ escape_in); // R17 R18
        reserved   = cfg_in.reserve_fourth && (res_reg == `IOA_RES_PERIOD); // R9
        aux_idx    = {1'b1, slot_data.primary};
        target     = {1'b0, slot_data.primary}; // R10
        to_proc    = 1'b0;
        if (cfg_in.varspeed) begin
            // Aux of a pair never takes its own slots here
            to_proc = ({1'b0, vs_reg} >=
                       {1'b0, eff_rate[slot_data.primary*`IOA_RATE_W +: `IOA_RATE_W]}); // R15 R16
        end else if (slot_data.has_aux && round_reg) begin // R11 R12
            if (installed_in[aux_idx]) begin
                target = aux_idx;
            end else if (cfg_in.aux1_redirect && slot_data.primary == '0) begin
                target = {1'b0, slot_data.primary}; // R8
            end else begin
                to_proc = 1'b1; // R7
            end
        end
        if (!installed_in[target]) begin
            to_proc = 1'b1; // R7
        end
        // Owner substitution only while the interlock is active
        if (ilk_in.active && ilk_in.mask[target]) begin // R14
            target = ilk_in.owner; // R13
        end
        if (reserved) begin
            to_proc = 1'b1; // R9
        end
        chan_block = block_of(io_block_in, target);
    end

    // Rotation slot, round parity, speed window and reserve count
    always_comb begin
        slot_next  = slot_reg;
        round_next = round_reg;
        vs_next    = vs_reg;
        res_next   = res_reg;
        if (tick) begin
            res_next = res_reg + 2'd1;
            // Reserved cycles leave the channel rotation where it was
            if (!reserved) begin
                slot_next = (`IOA_CIW-1)'(wrap_inc({1'b0, slot_reg}, {1'b0, SLOT_LAST})); // R1
                // Round parity and speed window step once per full rotation
                if (slot_reg == SLOT_LAST) begin
                    round_next = ~round_reg; // R11
                    vs_next    = wrap_inc(vs_reg, `IOA_VS_ROUNDS - 3'd1);
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            slot_reg  <= '0;
            round_reg <= 1'b0;
            res_reg   <= 2'd0;
            vs_reg    <= 3'd0;
        end else begin
            slot_reg  <= slot_next;
            round_reg <= round_next;
            res_reg   <= res_next;
            vs_reg    <= vs_next;
        end
    end

    // Cycle owner and processor permission, held for one memory cycle
    always_comb begin
        offer_next       = offer_reg;
        grant_next       = grant_reg;
        grant_next.valid = 1'b0;
        owner_next       = owner_reg;
        go_next          = go_reg;
        stall_next       = stall_reg;
        if (tick) begin
            offer_next.valid = !to_proc; // R1
            offer_next.chan  = target;
            owner_next       = '0;
            if (!to_proc && demand_in[target]) begin
                grant_next.valid   = 1'b1; // R2 R6
                grant_next.chan    = target;
                owner_next[target] = 1'b1; // R20
                if (cfg_in.banked) begin
                    stall_next = proc_req_in && (proc_block_in == chan_block); // R4
                    go_next    = proc_req_in && (proc_block_in != chan_block); // R5
                end else begin
                    // One shared memory: a waiting processor always loses the cycle
                    stall_next = proc_req_in;
                    go_next    = 1'b0;
                end
            end else begin
                owner_next[NCH] = 1'b1; // R3 R20
                stall_next      = 1'b0;
                go_next         = proc_req_in; // R3
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            offer_reg <= '0;
            grant_reg <= '0;
            owner_reg <= {1'b1, {NCH{1'b0}}};
            go_reg    <= 1'b0;
            stall_reg <= 1'b0;
        end else begin
            offer_reg <= offer_next;
            grant_reg <= grant_next;
            owner_reg <= owner_next;
            go_reg    <= go_next;
            stall_reg <= stall_next;
        end
    end

    // Pair busy follows demand on every clock, not only at ticks
    always_comb begin
        for (int i = 0; i < NPRI; i++) begin
            busy_next[i] = cfg_in.varspeed && demand_in[i]; // R16
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_reg <= '0;
        end else begin
            busy_reg <= busy_next;
        end
    end

    assign offer_out      = offer_reg;
    assign grant_out      = grant_reg;
    assign owner_out      = owner_reg;
    assign proc_go_out    = go_reg;
    assign proc_stall_out = stall_reg;
    assign pair_busy_out  = busy_reg;
endmodule : ioa_cycle_allocator
`default_nettype wire

// ### rtl/ioa_defs.svh
// Constants of the I/O memory cycle allocator
`ifndef IOA_DEFS_SVH
`define IOA_DEFS_SVH
`define IOA_NPRI          4
`define IOA_NCH           8
`define IOA_CIW           3
`define IOA_RATE_W        3
`define IOA_BLK_W         4
`define IOA_CLK_NS        10
`define IOA_MEM_CYCLE_NS  2000
`define IOA_CNT_W         16
`define IOA_RES_PERIOD    2'd3
`define IOA_VS_ROUNDS     3'd6
`define IOA_RATE_MIN      3'd1
`define IOA_RATE_MAX      3'd6
`define IOA_SECTOR_CAP    4'd6
`define IOA_SLOT_MAP      4'b0001
`define IOA_HOME_SECTOR   4'b1100
`endif

// ### rtl/ioa_pkg.sv
// Types shared by the I/O memory cycle allocator
`include "ioa_defs.svh"
package ioa_pkg;
    typedef struct packed {
        logic banked;
        logic varspeed;
        logic reserve_fourth;
        logic aux1_redirect;
    } ioa_cfg_t;

    typedef struct packed {
        logic                     active;
        logic [`IOA_NCH-1:0]      mask;
        logic [`IOA_CIW-1:0]      owner;
    } ioa_ilk_t;

    typedef struct packed {
        logic                     valid;
        logic [`IOA_CIW-1:0]      chan;
    } ioa_grant_t;

    typedef struct packed {
        logic                     has_aux;
        logic [`IOA_CIW-2:0]      primary;
    } ioa_slot_t;
endpackage : ioa_pkg

// ### rtl/ioa_slot_rom.sv
// Rotation slot table with registered read
`timescale 1ns/10ps
`default_nettype none
`include "ioa_defs.svh"
module ioa_slot_rom #(
    parameter int                  NPRI    = `IOA_NPRI,
    parameter logic [NPRI-1:0]     AUX_MAP = `IOA_SLOT_MAP
) (
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    input  wire logic [`IOA_CIW-2:0]   addr_in,
    output ioa_pkg::ioa_slot_t         data_out
);
    ioa_pkg::ioa_slot_t data_reg;
    ioa_pkg::ioa_slot_t data_next;

    always_comb begin
        data_next.primary = addr_in;
        data_next.has_aux = AUX_MAP[addr_in];
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_reg <= '0;
        end else begin
            data_reg <= data_next;
        end
    end

    assign data_out = data_reg;
endmodule : ioa_slot_rom
`default_nettype wire

// ### dv/ioa_alloc_chk_sva.sv
// Assertion checker for the memory cycle allocator ports
`timescale 1ns/10ps
`default_nettype none
module ioa_alloc_chk #(
    parameter int NPRI       = 4,
    parameter int MEM_CYC_NS = 2000
) (
    input wire logic                clk_in,
    input wire logic                resetn_in,
    input wire ioa_pkg::ioa_cfg_t   cfg_in,
    input wire logic [NPRI*8-1:0]   io_block_in,
    input wire logic                proc_req_in,
    input wire logic [3:0]          proc_block_in,
    input wire ioa_pkg::ioa_grant_t offer_out,
    input wire ioa_pkg::ioa_grant_t grant_out,
    input wire logic [2*NPRI:0]     owner_out,
    input wire logic                proc_go_out,
    input wire logic                proc_stall_out
);
    localparam int CYC = MEM_CYC_NS / 10;
    logic [15:0] gap_reg;
    logic [15:0] gap_next;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // Clocks since the last grant, saturating
    always_comb begin
        gap_next = grant_out.valid ? 16'h0001 : gap_reg + {15'h0000, gap_reg != 16'hffff};
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gap_reg <= 16'hffff;
        end else begin
            gap_reg <= gap_next;
        end
    end
    property p_onehot; $onehot(owner_out); endproperty
    a_onehot: assert property (p_onehot) else $error("owner not one-hot");
    property p_pulse; grant_out.valid |=> !grant_out.valid; endproperty
    a_pulse: assert property (p_pulse) else $error("grant longer than one clock");
    property p_offer; grant_out.valid |-> offer_out == grant_out; endproperty
    a_offer: assert property (p_offer) else $error("grant to channel not offered");
    property p_owner; grant_out.valid |-> owner_out[grant_out.chan]; endproperty
    a_owner: assert property (p_owner) else $error("granted channel not owner");
    property p_proc; owner_out[2*NPRI] |-> !grant_out.valid && !proc_stall_out; endproperty
    a_proc: assert property (p_proc) else $error("processor cycle with grant or stall");
    property p_same;
        grant_out.valid && $past(cfg_in.banked && proc_req_in) &&
        ($past(proc_block_in) == 4'($past(io_block_in) >> (4 * grant_out.chan)))
        |-> proc_stall_out && !proc_go_out;
    endproperty
    a_same: assert property (p_same) else $error("same block conflict not stalled");
    property p_diff;
        grant_out.valid && $past(cfg_in.banked && proc_req_in) &&
        ($past(proc_block_in) != 4'($past(io_block_in) >> (4 * grant_out.chan)))
        |-> proc_go_out && !proc_stall_out;
    endproperty
    a_diff: assert property (p_diff) else $error("different block stalled");
    property p_gap; grant_out.valid |-> gap_reg >= CYC; endproperty
    a_gap: assert property (p_gap) else $error("two grants in one memory cycle");
endmodule : ioa_alloc_chk
bind ioa_cycle_allocator ioa_alloc_chk #(.NPRI(NPRI), .MEM_CYC_NS(MEM_CYC_NS)) u_chk (
    .clk_in(clk_in), .resetn_in(resetn_in), .cfg_in(cfg_in), .io_block_in(io_block_in),
    .proc_req_in(proc_req_in), .proc_block_in(proc_block_in), .offer_out(offer_out),
    .grant_out(grant_out), .owner_out(owner_out), .proc_go_out(proc_go_out),
    .proc_stall_out(proc_stall_out));
`default_nettype wire

// ### dv/ioa_periph_model.sv
// Peripheral controls raising demand and counting moved characters
`timescale 1ns/10ps
`default_nettype none
module ioa_periph_model (
    input  wire logic                clk_in,
    input  wire logic                resetn_in,
    input  wire logic [7:0]          want_in,
    input  wire ioa_pkg::ioa_grant_t grant_in,
    output logic [7:0]               demand_out,
    output logic [15:0]              chars_out
);
    // Demand only on channels assigned to the operation
    assign demand_out = want_in;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            chars_out <= 16'h0000;
        end else if (grant_in.valid) begin
            chars_out <= chars_out + 16'h0001;
        end
    end
endmodule : ioa_periph_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the memory cycle allocator
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                clk_in, resetn_in = 1'b0, preq = 1'b1, go, stall;
    ioa_pkg::ioa_cfg_t   cfg = '0;
    ioa_pkg::ioa_ilk_t   ilk = '0;
    ioa_pkg::ioa_grant_t offer, grant;
    logic [7:0]          inst = 8'hff, want = 8'h00, demand;
    logic [11:0]         rate = 12'h000;
    logic [3:0]          esc = 4'h0, pblk = 4'h0, busy;
    logic [31:0]         blk = 32'h0;
    logic [8:0]          owner;
    logic [15:0]         chars;
    int                  err_count = 0, checks = 0;

    // Four clocks per memory cycle keeps the run short
    ioa_cycle_allocator #(.MEM_CYC_NS(40)) uut (
        .clk_in(clk_in), .resetn_in(resetn_in), .cfg_in(cfg), .installed_in(inst),
        .demand_in(demand), .ilk_in(ilk), .rate_code_in(rate), .escape_in(esc),
        .io_block_in(blk), .proc_req_in(preq), .proc_block_in(pblk), .offer_out(offer),
        .grant_out(grant), .owner_out(owner), .proc_go_out(go), .proc_stall_out(stall),
        .pair_busy_out(busy));
    ioa_periph_model u_per (.clk_in(clk_in), .resetn_in(resetn_in), .want_in(want),
        .grant_in(grant), .demand_out(demand), .chars_out(chars));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic rst(input logic [3:0] c, input logic [7:0] i, input logic [7:0] w);
        cfg = ioa_pkg::ioa_cfg_t'(c);
        inst = i;
        want = w;
        resetn_in = 1'b0;
        repeat (6) @(negedge clk_in);
        resetn_in = 1'b1;
    endtask : rst

    // Expected offers, one {valid,chan} nibble per memory cycle, first cycle leftmost
    task automatic seq(input logic [31:0] exp);
        logic [3:0] e;
        logic       g;
        logic       same;
        for (int i = 0; i < 8; i++) begin
            repeat (4) @(posedge clk_in);
            @(negedge clk_in);
            e = exp[4*(7-i) +: 4];
            g = e[3] && demand[e[2:0]];
            same = pblk == blk[4*e[2:0] +: 4];
            chk("offer.valid", offer.valid, e[3]);
            if (e[3]) chk("offer.chan", offer.chan, e[2:0]);
            chk("grant", grant.valid, g);
            chk("owner", owner, g ? 9'h001 << e[2:0] : 9'h100);
            chk("stall", stall, g && preq && (!cfg.banked || same));
            chk("go", go, g ? cfg.banked && preq && !same : preq);
        end
    endtask : seq

    task automatic t_rotation;
        rst(4'h0, 8'hff, 8'h06);
        seq(32'h89abc9ab);
        chk("chars", chars, 32'd4);
        $display("rotation done");
    endtask : t_rotation

    task automatic t_slots;
        rst(4'h0, 8'heb, 8'hff);
        seq(32'h890b090b);
        rst(4'h1, 8'heb, 8'hff);
        seq(32'h890b890b);
        rst(4'h2, 8'hff, 8'hff);
        seq(32'h89a0bc90);
        $display("slots done");
    endtask : t_slots

    task automatic t_interlock;
        ilk = '{1'b1, 8'h06, 3'd1};
        rst(4'h0, 8'hff, 8'hff);
        seq(32'h899bc99b);
        ilk.active = 1'b0;
        seq(32'h89abc9ab);
        $display("interlock done");
    endtask : t_interlock

    task automatic t_banked;
        blk = 32'h0000_0050;
        pblk = 4'h5;
        rst(4'h8, 8'hff, 8'h02);
        seq(32'h89abc9ab);
        pblk = 4'h6;
        seq(32'h89abc9ab);
        $display("banked done");
    endtask : t_banked

    // Counts offers per channel over six full rounds
    task automatic t_varspeed;
        logic [31:0] cnt;
        // Codes 0 and 7 lie outside one to six and must be clamped
        rate = 12'he1d;
        for (int k = 0; k < 2; k++) begin
            esc = k ? 4'h2 : 4'h0;
            rst(4'h4, 8'hff, 8'h0f);
            cnt = 32'h0;
            repeat (24) begin
                repeat (4) @(posedge clk_in);
                @(negedge clk_in);
                if (offer.valid) cnt = cnt + (32'h1 << (4 * offer.chan));
            end
            chk("rates", cnt, k ? 32'h2135 : 32'h5115);
            chk("busy", busy, 32'hf);
        end
        $display("varspeed done");
    endtask : t_varspeed

    initial begin
        repeat (5000) @(posedge clk_in);
        err_count++;
        finish_test();
    end

    initial begin
        @(negedge clk_in);
        t_rotation();
        t_slots();
        t_interlock();
        t_banked();
        t_varspeed();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
